// File: hw/dcl_defs.svh
// Register offsets, field positions, reset values and timing figures of the line config bank.
`ifndef DCL_DEFS_SVH
`define DCL_DEFS_SVH

`define DCL_OFF_TXBUF      8'h00
`define DCL_OFF_RXBUF      8'h04
`define DCL_OFF_USERBASE   8'h08
`define DCL_OFF_CTRL       8'h0C
`define DCL_OFF_OUTADR_LO  8'h10
`define DCL_OFF_OUTADR_HI  8'h14
`define DCL_OFF_INADR_LO   8'h18
`define DCL_OFF_INADR_HI   8'h1C
`define DCL_OFF_LINE_LO    8'h20
`define DCL_OFF_LINE_HI    8'h24
`define DCL_OFF_STATUS     8'h28

`define DCL_CTRL_LEVEL     0
`define DCL_LINE_ROLE      0
`define DCL_LINE_ATTEND    1
`define DCL_LINE_WIRING    2
`define DCL_LINE_CTSCHK    3
`define DCL_LINE_TWO_DLY   15:8
`define DCL_LINE_FOUR_DLY  23:16

`define DCL_LINE_LO_RST    32'h0001_0100
`define DCL_LINE_HI_RST    32'h0000_0000
`define DCL_ADDR_RST       64'h0000_0000_0000_0000
`define DCL_GEN_TXBUF      16'h0000
`define DCL_GEN_RXBUF      16'h0000

`define DCL_STEP_NS        1750000
`define DCL_CLK_NS         50
`define DCL_LAST_CHAR      3'h7

`endif

// File: hw/dcl_pkg.sv
// Types and the character selection shared by the line config bank modules.
package dcl_pkg;

	typedef enum logic [1:0] {
		DCL_IDLE = 2'b00,
		DCL_WAIT = 2'b01,
		DCL_CTS  = 2'b10,
		DCL_SEND = 2'b11
	} dcl_seq_e;

	typedef logic [7:0] dcl_char_t;

	// Character 0 is the most significant byte, so it goes out first on the line.
	function automatic dcl_char_t dcl_char_of(input logic [63:0] adr, input logic [2:0] idx);
		dcl_char_of = adr[8 * (7 - idx) +: 8];
	endfunction

endpackage

// File: hw/dcl_cfg_if.sv
// Settings from the register bank to the line sequencer, and its state back.
interface dcl_cfg_if;
	logic [63:0] out_addr;
	logic [63:0] in_addr;
	logic        two_wire;
	logic        cts_check;
	logic [7:0]  two_dly;
	logic [7:0]  four_dly;
	logic        rts;
	logic        tx_start;
	logic        addr_match;
	logic        addr_done;
	logic        busy;

	modport regs (output out_addr, in_addr, two_wire, cts_check, two_dly, four_dly,
		input rts, tx_start, addr_match, addr_done, busy);
	modport seq (input out_addr, in_addr, two_wire, cts_check, two_dly, four_dly,
		output rts, tx_start, addr_match, addr_done, busy);
endinterface

// File: hw/dcl_line_seq.sv
// Line sequencer: RTS to CTS delay, outgoing header characters, incoming address compare.
`include "dcl_defs.svh"

module dcl_line_seq
	import dcl_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = `DCL_STEP_NS / `DCL_CLK_NS
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	dcl_cfg_if.seq          cfg,
	input  wire logic       tx_req,
	input  wire logic       cts,
	input  wire logic [2:0] hdr_idx,
	output logic      [7:0] hdr_char,
	input  wire logic       rx_hdr_start,
	input  wire logic       rx_char_stb,
	input  wire logic [7:0] rx_char
);

	dcl_seq_e    state;
	logic [15:0] step_cnt;
	logic [7:0]  dly_cnt;
	logic [2:0]  rx_idx;
	logic        match_run;

	// The wiring bit picks which transmit delay is in force.
	wire  [7:0] sel_dly   = cfg.two_wire ? cfg.two_dly : cfg.four_dly;
	wire        step_end  = (step_cnt == 16'h0000);
	wire        char_ok   = (rx_char == dcl_char_of(cfg.in_addr, rx_idx));
	wire        cts_ok    = !cfg.cts_check || cts;

	assign cfg.busy = (state != DCL_IDLE);

	// RTS is raised at once; CTS is only looked at after the programmed count of steps.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state        <= DCL_IDLE;
			step_cnt     <= 16'h0000;
			dly_cnt      <= 8'h00;
			cfg.rts      <= 1'b0;
			cfg.tx_start <= 1'b0;
		end else if (ce) begin
			if (!tx_req) begin
				state        <= DCL_IDLE;
				cfg.rts      <= 1'b0;
				cfg.tx_start <= 1'b0;
			end else begin
				case (state)
					DCL_IDLE: begin
						cfg.rts  <= 1'b1;
						step_cnt <= 16'(STEP_CYCLES - 1);
						dly_cnt  <= sel_dly;
						// Without CTS checking no delay is imposed; a zero count skips it too.
						state    <= (cfg.cts_check && sel_dly != 8'h00) ? DCL_WAIT : DCL_CTS;
					end
					DCL_WAIT: begin
						if (step_end) begin
							step_cnt <= 16'(STEP_CYCLES - 1);
							dly_cnt  <= dly_cnt - 8'h01;
							if (dly_cnt == 8'h01)
								state <= DCL_CTS;
						end else begin
							step_cnt <= step_cnt - 16'h0001;
						end
					end
					DCL_CTS: begin
						if (cts_ok) begin
							state        <= DCL_SEND;
							cfg.tx_start <= 1'b1;
						end
					end
					DCL_SEND: state <= DCL_SEND;
					default:  state <= DCL_IDLE;
				endcase
			end
		end
	end

	// The outgoing header character follows the index one cycle later.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hdr_char <= 8'h00;
		else if (ce)
			hdr_char <= dcl_char_of(cfg.out_addr, hdr_idx);
	end

	// A header start restarts the compare; the verdict stands until the next start.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_idx         <= 3'h0;
			match_run      <= 1'b0;
			cfg.addr_match <= 1'b0;
			cfg.addr_done  <= 1'b0;
		end else if (ce) begin
			if (rx_hdr_start) begin
				rx_idx         <= 3'h0;
				match_run      <= 1'b1;
				cfg.addr_match <= 1'b0;
				cfg.addr_done  <= 1'b0;
			end else if (rx_char_stb && !cfg.addr_done) begin
				rx_idx    <= rx_idx + 3'h1;
				match_run <= match_run && char_ok;
				if (rx_idx == `DCL_LAST_CHAR) begin
					cfg.addr_done  <= 1'b1;
					cfg.addr_match <= match_run && char_ok;
				end
			end
		end
	end

	default clocking dcl_cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Transmission begins only after CTS has been seen or when CTS checking is off, and never without RTS.
	a_start_after_cts: assert property (ce && state == DCL_CTS && !cts_ok && tx_req
		|=> !cfg.tx_start) else $error("Transmit started without CTS.");
	a_start_with_rts: assert property (cfg.tx_start |-> cfg.rts)
		else $error("Transmit start without RTS.");
	a_rts_drop: assert property (ce && !tx_req
		|=> !cfg.rts && !cfg.tx_start)
		else $error("Request to send kept after the request ended.");
	a_hdr_char_sel: assert property (ce
		|=> hdr_char == dcl_char_of($past(cfg.out_addr), $past(hdr_idx)))
		else $error("Header character does not follow address.");
	a_match_verdict: assert property (ce && rx_char_stb && !rx_hdr_start
		&& !cfg.addr_done && rx_idx == `DCL_LAST_CHAR
		|=> cfg.addr_done && cfg.addr_match == ($past(match_run) && $past(char_ok)))
		else $error("Address compare verdict wrong.");
	// Each enabled cycle of a running wait, save the one where a step ends, takes exactly one count off the step counter.
	a_wait_bounded: assert property (ce && tx_req && state == DCL_WAIT && !step_end
		|=> step_cnt == $past(step_cnt) - 16'h0001)
		else $error("Delay step counter stalled.");
	c_send: cover property (state == DCL_WAIT ##[1:1000] cfg.tx_start);
	c_match: cover property (cfg.addr_done && cfg.addr_match);
	c_mismatch: cover property (cfg.addr_done && !cfg.addr_match);

endmodule

// File: hw/dcl_regs.sv
// Data-communication line configuration register bank with APB access.
// Operation
// - Outgoing text is fetched from the buffer at the 16-bit transmit base.
// - Incoming text is stored into the buffer at the 16-bit receive base.
// - Higher-level program writes get the user memory base added.
// - Lower-level programs use buffer bases fixed at generation, not written.
// - Eight outgoing terminal address characters go into each message header.
// - Received header address characters are compared with the incoming address.
// - Both terminal addresses reset to all zero characters.
// - A 64-bit line characteristics group packs the line option settings.
// - Role bit: 0 initiates, 1 responds; resets to 0.
// - Attendance bit: 0 no operator, 1 operator present.
// - Two-wire transmit delay resets to one 1.75 ms step.
// - With CTS checking, wait the delay steps after RTS, then start on CTS.
// - Wiring bit selects four-wire delays at 0, two-wire delays at 1.
`include "dcl_defs.svh"

module dcl_regs
	import dcl_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = `DCL_STEP_NS / `DCL_CLK_NS,
	parameter logic [15:0] GEN_TXBUF   = `DCL_GEN_TXBUF,
	parameter logic [15:0] GEN_RXBUF   = `DCL_GEN_RXBUF
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic      [15:0] TX_BUF_BASE,
	output logic      [15:0] RX_BUF_BASE,
	output logic             STATION_ROLE,
	output logic             OPERATOR_PRESENT,
	input  wire logic        TX_REQ,
	input  wire logic        CTS,
	output logic             RTS,
	output logic             TX_START,
	input  wire logic [2:0]  HDR_IDX,
	output logic      [7:0]  HDR_CHAR,
	input  wire logic        RX_HDR_START,
	input  wire logic        RX_CHAR_STB,
	input  wire logic [7:0]  RX_CHAR,
	output logic             ADDR_MATCH,
	output logic             ADDR_DONE
);

	dcl_cfg_if cfg ();

	logic [15:0] user_base;
	logic        higher_level;
	logic [31:0] line_lo;
	logic [31:0] line_hi;
	logic [63:0] out_addr;
	logic [63:0] in_addr;

	// Bus phase decode: the answer is prepared in setup and given in the access cycle.
	wire        setup_ph  = PSEL && !PENABLE;
	wire        commit    = PSEL && PENABLE && PREADY;
	wire        wr_commit = commit && PWRITE;
	wire        hit_tx    = (PADDR == `DCL_OFF_TXBUF);
	wire        hit_rx    = (PADDR == `DCL_OFF_RXBUF);
	wire        hit_ub    = (PADDR == `DCL_OFF_USERBASE);
	wire        hit_ctrl  = (PADDR == `DCL_OFF_CTRL);
	wire        hit_oal   = (PADDR == `DCL_OFF_OUTADR_LO);
	wire        hit_oah   = (PADDR == `DCL_OFF_OUTADR_HI);
	wire        hit_ial   = (PADDR == `DCL_OFF_INADR_LO);
	wire        hit_iah   = (PADDR == `DCL_OFF_INADR_HI);
	wire        hit_ll    = (PADDR == `DCL_OFF_LINE_LO);
	wire        hit_lh    = (PADDR == `DCL_OFF_LINE_HI);
	wire        hit_st    = (PADDR == `DCL_OFF_STATUS);
	wire        mapped    = hit_tx || hit_rx || hit_ub || hit_ctrl || hit_oal || hit_oah
		|| hit_ial || hit_iah || hit_ll || hit_lh || hit_st;
	// Status is read only, so a write to it is answered as an error.
	wire        bad_acc   = !mapped || (PWRITE && hit_st);

	// Higher-level programs give a user-relative address; it is made absolute here.
	wire [15:0] abs_addr  = PWDATA[15:0] + user_base;
	wire        base_wr   = wr_commit && higher_level;
	// Dropping back to the lower level reloads the generated buffer locations.
	wire        to_lower  = wr_commit && hit_ctrl && !PWDATA[`DCL_CTRL_LEVEL];

	wire [31:0] status_w  = {27'h0000000, cfg.busy, cfg.addr_done, cfg.addr_match,
		cfg.tx_start, cfg.rts};
	wire [31:0] rd_mux    =
		hit_tx   ? {16'h0000, TX_BUF_BASE} :
		hit_rx   ? {16'h0000, RX_BUF_BASE} :
		hit_ub   ? {16'h0000, user_base} :
		hit_ctrl ? {31'h00000000, higher_level} :
		hit_oal  ? out_addr[31:0] :
		hit_oah  ? out_addr[63:32] :
		hit_ial  ? in_addr[31:0] :
		hit_iah  ? in_addr[63:32] :
		hit_ll   ? line_lo :
		hit_lh   ? line_hi :
		hit_st   ? status_w : 32'h00000000;

	// One wait-free access: PREADY rises for the access cycle only.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else if (CE) begin
			PREADY  <= setup_ph;
			PRDATA  <= (setup_ph && !PWRITE) ? rd_mux : 32'h00000000;
			PSLVERR <= setup_ph && bad_acc;
		end
	end

	// Buffer bases hold generated values unless a higher-level program writes them.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			TX_BUF_BASE  <= GEN_TXBUF;
			RX_BUF_BASE  <= GEN_RXBUF;
			user_base    <= 16'h0000;
			higher_level <= 1'b0;
		end else if (CE) begin
			if (to_lower) begin
				TX_BUF_BASE <= GEN_TXBUF;
				RX_BUF_BASE <= GEN_RXBUF;
			end else begin
				if (base_wr && hit_tx)
					TX_BUF_BASE <= abs_addr;
				if (base_wr && hit_rx)
					RX_BUF_BASE <= abs_addr;
			end
			if (wr_commit && hit_ub)
				user_base <= PWDATA[15:0];
			if (wr_commit && hit_ctrl)
				higher_level <= PWDATA[`DCL_CTRL_LEVEL];
		end
	end

	// Terminal addresses and the line group change only on a committed write.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			out_addr <= `DCL_ADDR_RST;
			in_addr  <= `DCL_ADDR_RST;
			line_lo  <= `DCL_LINE_LO_RST;
			line_hi  <= `DCL_LINE_HI_RST;
		end else if (CE && wr_commit) begin
			if (hit_oal)
				out_addr[31:0] <= PWDATA;
			if (hit_oah)
				out_addr[63:32] <= PWDATA;
			if (hit_ial)
				in_addr[31:0] <= PWDATA;
			if (hit_iah)
				in_addr[63:32] <= PWDATA;
			if (hit_ll)
				line_lo <= PWDATA;
			if (hit_lh)
				line_hi <= PWDATA;
		end
	end

	// Line group fields feed the sequencer directly.
	assign cfg.out_addr  = out_addr;
	assign cfg.in_addr   = in_addr;
	assign cfg.two_wire  = line_lo[`DCL_LINE_WIRING];
	assign cfg.cts_check = line_lo[`DCL_LINE_CTSCHK];
	assign cfg.two_dly   = line_lo[`DCL_LINE_TWO_DLY];
	assign cfg.four_dly  = line_lo[`DCL_LINE_FOUR_DLY];

	// Role and attendance leave as registered copies so the pins never glitch.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			STATION_ROLE     <= 1'b0;
			OPERATOR_PRESENT <= 1'b0;
		end else if (CE) begin
			STATION_ROLE     <= line_lo[`DCL_LINE_ROLE];
			OPERATOR_PRESENT <= line_lo[`DCL_LINE_ATTEND];
		end
	end

	dcl_line_seq #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_seq (
		.clk          (CLK),
		.rst_n        (RST_N),
		.ce           (CE),
		.cfg          (cfg.seq),
		.tx_req       (TX_REQ),
		.cts          (CTS),
		.hdr_idx      (HDR_IDX),
		.hdr_char     (HDR_CHAR),
		.rx_hdr_start (RX_HDR_START),
		.rx_char_stb  (RX_CHAR_STB),
		.rx_char      (RX_CHAR)
	);

	// Sequencer flops reach the pins without further logic.
	assign RTS        = cfg.rts;
	assign TX_START   = cfg.tx_start;
	assign ADDR_MATCH = cfg.addr_match;
	assign ADDR_DONE  = cfg.addr_done;

	default clocking dcl_rcb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// A higher-level base write stores the relative value plus the user base, wrapping at 16 bits.
	a_txbase_abs: assert property (CE && wr_commit && hit_tx && higher_level
		|=> TX_BUF_BASE == $past(PWDATA[15:0]) + $past(user_base))
		else $error("Transmit base not made absolute.");
	a_rxbase_abs: assert property (CE && wr_commit && hit_rx && higher_level
		|=> RX_BUF_BASE == $past(PWDATA[15:0]) + $past(user_base))
		else $error("Receive base not made absolute.");

	// At the lower level the generated bases stand, and leaving the higher level restores them.
	a_lower_fixed: assert property (!higher_level && !(wr_commit && hit_ctrl)
		|=> TX_BUF_BASE == $past(TX_BUF_BASE) && RX_BUF_BASE == $past(RX_BUF_BASE))
		else $error("Lower-level base changed.");
	a_level_reload: assert property (CE && to_lower
		|=> TX_BUF_BASE == GEN_TXBUF && RX_BUF_BASE == GEN_RXBUF)
		else $error("Generated bases not restored.");
	a_ctrl_level: assert property (CE && wr_commit && hit_ctrl
		|=> higher_level == $past(PWDATA[`DCL_CTRL_LEVEL]))
		else $error("Language level bit not stored.");

	// Nothing but its own write may change a stored word; a stray change would corrupt the line.
	a_outadr_hold: assert property (!(wr_commit && (hit_oal || hit_oah))
		|=> $stable(out_addr))
		else $error("Outgoing address changed unwritten.");
	a_inadr_hold: assert property (!(wr_commit && (hit_ial || hit_iah))
		|=> $stable(in_addr))
		else $error("Incoming address changed unwritten.");
	a_line_hold: assert property (!(wr_commit && (hit_ll || hit_lh))
		|=> $stable(line_lo) && $stable(line_hi))
		else $error("Line group changed unwritten.");
	a_userbase_hold: assert property (!(wr_commit && hit_ub)
		|=> $stable(user_base))
		else $error("User base changed unwritten.");
	a_status_ro: assert property (CE && wr_commit && hit_st
		|=> $stable(line_lo) && $stable(out_addr) && $stable(in_addr))
		else $error("Status write reached a stored word.");

	// The bus answers every enabled setup in the next cycle, and in no other cycle.
	a_ready_after_setup: assert property (CE && setup_ph
		|=> PREADY)
		else $error("Ready missing after setup.");
	a_ready_only_setup: assert property (CE && !setup_ph
		|=> !PREADY)
		else $error("Ready raised without setup.");
	a_pready_pulse: assert property (CE && PREADY
		|=> !PREADY)
		else $error("Ready held past one access cycle.");

	// Refused accesses carry the error flag; accepted ones never do.
	a_err_unmapped: assert property (CE && setup_ph && !mapped
		|=> PREADY && PSLVERR)
		else $error("Unmapped access not refused.");
	a_err_status_wr: assert property (CE && setup_ph && PWRITE && hit_st
		|=> PREADY && PSLVERR)
		else $error("Status write not refused.");
	a_err_clean: assert property (CE && setup_ph && !bad_acc
		|=> !PSLVERR)
		else $error("Error flag on a legal access.");
	a_err_flag_pulse: assert property (CE && !setup_ph
		|=> !PSLVERR)
		else $error("Error flag outside an access cycle.");

	// Read data stands only in the access cycle of a read and shows the addressed register.
	a_rdata_idle: assert property (CE && !setup_ph
		|=> PRDATA == 32'h00000000)
		else $error("Read data outside access cycle.");
	a_rdata_txbuf: assert property (CE && setup_ph && !PWRITE && hit_tx
		|=> PRDATA == {16'h0000, $past(TX_BUF_BASE)})
		else $error("Transmit base read back wrong.");
	a_rdata_rxbuf: assert property (CE && setup_ph && !PWRITE && hit_rx
		|=> PRDATA == {16'h0000, $past(RX_BUF_BASE)})
		else $error("Receive base read back wrong.");
	a_rdata_ctrl: assert property (CE && setup_ph && !PWRITE && hit_ctrl
		|=> PRDATA == {31'h00000000, $past(higher_level)})
		else $error("Language level read back wrong.");

	// Role and attendance pins follow the group one enabled cycle late.
	a_role_follow: assert property (CE
		|=> STATION_ROLE == $past(line_lo[`DCL_LINE_ROLE]))
		else $error("Role pin does not follow the group.");
	a_attend_follow: assert property (CE
		|=> OPERATOR_PRESENT == $past(line_lo[`DCL_LINE_ATTEND]))
		else $error("Attendance pin does not follow the group.");
	a_line_write: assert property (CE && wr_commit && hit_ll
		##1 CE [*2] |-> STATION_ROLE == line_lo[`DCL_LINE_ROLE])
		else $error("Role pin stale after a group write.");

	// Main scenarios: a relocated base write and a refused access.
	c_wr_txbase: cover property (wr_commit && hit_tx && higher_level);
	c_err_acc: cover property (PREADY && PSLVERR);

endmodule

// File: testbench/dcl_modem.sv
// Modem model for the far side of the line: answers request to send with clear to send.
module dcl_modem (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       rts,
	input  wire logic [7:0] lag,
	output logic            cts
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] cnt;

	// Clear to send comes only after the lag and drops with request to send, as a data set turns round.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
			cts <= 1'h0;
		end else if (!rts) begin
			cnt <= 8'h00;
			cts <= 1'h0;
		end else if (cnt >= lag) begin
			cts <= 1'h1;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

// File: testbench/dcl_regs_bench.sv
// Self-checking bench for the line configuration register bank.
`include "dcl_defs.svh"

module dcl_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import dcl_pkg::*;

	localparam int STEP = 4;

	logic        clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, rx_char, hdr_char, lag;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] tx_base, rx_base;
	logic        role, attend, rts, cts, tx_req, tx_start, hdr_start, rx_stb;
	logic        addr_match, addr_done, rerr;
	logic [2:0]  hdr_idx;
	logic [63:0] oa;
	int          num_errors, comparisons, cnt;

	dcl_regs #(.STEP_CYCLES(STEP), .GEN_TXBUF(16'h1A00), .GEN_RXBUF(16'h2B00)) dut_u (
		.CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .TX_BUF_BASE(tx_base), .RX_BUF_BASE(rx_base),
		.STATION_ROLE(role), .OPERATOR_PRESENT(attend), .TX_REQ(tx_req), .CTS(cts),
		.RTS(rts), .TX_START(tx_start), .HDR_IDX(hdr_idx), .HDR_CHAR(hdr_char),
		.RX_HDR_START(hdr_start), .RX_CHAR_STB(rx_stb), .RX_CHAR(rx_char),
		.ADDR_MATCH(addr_match), .ADDR_DONE(addr_done));

	dcl_modem modem_u (.clk(clk), .rst_n(rst_n), .rts(rts), .lag(lag), .cts(cts));

	// Clock of 50 ns period.
	always #25 clk = ~clk;

	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; ready, read data and error are taken at the rising edge that ends it.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic got;
		got = 1'h0;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		for (n = 0; n < 50 && !got; n++) begin
			@(posedge clk);
			if (pready === 1'h1) begin
				rdat = prdata;
				rerr = pslverr;
				got = 1'h1;
			end
		end
		psel <= 1'h0;
		penable <= 1'h0;
		if (!got) begin
			num_errors++;
			end_sim();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eerr);
		apb(1'h1, a, d);
		chk("write error flag", {31'h0, eerr}, {31'h0, rerr});
	endtask

	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp,
		input logic eerr);
		apb(1'h0, a, 32'h0);
		chk(what, exp, rdat);
		chk("read error flag", {31'h0, eerr}, {31'h0, rerr});
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	// Sends a full header address and checks the compare verdict.
	task automatic hdr_cmp(input logic [63:0] c, input logic exp);
		int i;
		@(posedge clk);
		hdr_start <= 1'h1;
		@(posedge clk);
		hdr_start <= 1'h0;
		for (i = 0; i < 8; i++) begin
			rx_stb <= 1'h1;
			rx_char <= c[8 * (7 - i) +: 8];
			@(posedge clk);
			rx_stb <= 1'h0;
			@(posedge clk);
		end
		settle();
		chk("addr_done", 32'h1, {31'h0, addr_done});
		chk("addr_match", {31'h0, exp}, {31'h0, addr_match});
	endtask

	// Requests a transmission and checks when the start comes; the caller gives the window, and the wait gives up after 300 cycles.
	task automatic xmit(input logic [31:0] line, input logic [7:0] l, input int lo, input int hi);
		wr(`DCL_OFF_LINE_LO, line, 1'h0);
		lag <= l;
		@(posedge clk);
		tx_req <= 1'h1;
		cnt = 0;
		while (tx_start !== 1'h1 && cnt < 300) begin
			@(negedge clk);
			cnt++;
		end
		if (cnt >= 300) begin
			num_errors++;
			end_sim();
		end
		chk("start delay in range", 32'h1, {31'h0, (cnt >= lo && cnt <= hi)});
		chk("rts while sending", 32'h1, {31'h0, rts});
		@(posedge clk);
		tx_req <= 1'h0;
		settle();
		chk("rts after end", 32'h0, {31'h0, rts});
		chk("tx_start after end", 32'h0, {31'h0, tx_start});
	endtask

	// Watchdog against a hung run.
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		end_sim();
	end

	initial begin
		int i;
		clk = 1'h0;
		rst_n = 1'h0;
		ce = 1'h1;
		{psel, penable, pwrite, tx_req, hdr_start, rx_stb} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		rx_char = 8'h00;
		hdr_idx = 3'h0;
		lag = 8'h00;
		num_errors = 0;
		comparisons = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		rd("txbuf", `DCL_OFF_TXBUF, 32'h1A00, 1'h0);
		rd("rxbuf", `DCL_OFF_RXBUF, 32'h2B00, 1'h0);
		rd("out lo", `DCL_OFF_OUTADR_LO, 32'h0, 1'h0);
		rd("out hi", `DCL_OFF_OUTADR_HI, 32'h0, 1'h0);
		rd("in lo", `DCL_OFF_INADR_LO, 32'h0, 1'h0);
		rd("in hi", `DCL_OFF_INADR_HI, 32'h0, 1'h0);
		rd("line lo", `DCL_OFF_LINE_LO, 32'h0001_0100, 1'h0);
		rd("line hi", `DCL_OFF_LINE_HI, 32'h0, 1'h0);
		chk("role pin", 32'h0, {31'h0, role});
		$display("test reset values done");
		wr(`DCL_OFF_TXBUF, 32'h0055, 1'h0);
		rd("txbuf lower", `DCL_OFF_TXBUF, 32'h1A00, 1'h0);
		wr(`DCL_OFF_USERBASE, 32'h0100, 1'h0);
		wr(`DCL_OFF_CTRL, 32'h1, 1'h0);
		wr(`DCL_OFF_TXBUF, 32'h0034, 1'h0);
		rd("txbuf higher", `DCL_OFF_TXBUF, 32'h0134, 1'h0);
		chk("tx base pin", 32'h0134, {16'h0, tx_base});
		wr(`DCL_OFF_RXBUF, 32'hFFF0, 1'h0);
		rd("rxbuf wrap", `DCL_OFF_RXBUF, 32'h00F0, 1'h0);
		chk("rx base pin", 32'h00F0, {16'h0, rx_base});
		wr(`DCL_OFF_CTRL, 32'h0, 1'h0);
		rd("txbuf reload", `DCL_OFF_TXBUF, 32'h1A00, 1'h0);
		chk("rx base reload", 32'h2B00, {16'h0, rx_base});
		wr(8'h2C, 32'h1, 1'h1);
		rd("unmapped", 8'h2C, 32'h0, 1'h1);
		wr(`DCL_OFF_STATUS, 32'h1F, 1'h1);
		rd("status", `DCL_OFF_STATUS, 32'h0, 1'h0);
		$display("test buffer bases done");
		oa = 64'h4142_4344_4546_4748;
		wr(`DCL_OFF_OUTADR_HI, oa[63:32], 1'h0);
		wr(`DCL_OFF_OUTADR_LO, oa[31:0], 1'h0);
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			hdr_idx <= i[2:0];
			settle();
			chk("hdr_char", {24'h0, oa[8 * (7 - i) +: 8]}, {24'h0, hdr_char});
		end
		// Clock enable low freezes the header character even though the index moves.
		@(posedge clk);
		ce <= 1'h0;
		hdr_idx <= 3'h0;
		settle();
		chk("hdr_char frozen", {24'h0, oa[7:0]}, {24'h0, hdr_char});
		@(posedge clk);
		ce <= 1'h1;
		settle();
		chk("hdr_char thawed", {24'h0, oa[63:56]}, {24'h0, hdr_char});
		wr(`DCL_OFF_INADR_HI, 32'h3132_3334, 1'h0);
		wr(`DCL_OFF_INADR_LO, 32'h3536_3738, 1'h0);
		hdr_cmp(64'h3132_3334_3536_3738, 1'h1);
		hdr_cmp(64'h3132_3534_3536_3738, 1'h0);
		rd("status after compare", `DCL_OFF_STATUS, 32'h8, 1'h0);
		$display("test terminal addresses done");
		wr(`DCL_OFF_LINE_LO, 32'h0001_0103, 1'h0);
		settle();
		chk("role pin", 32'h1, {31'h0, role});
		chk("attend pin", 32'h1, {31'h0, attend});
		wr(`DCL_OFF_LINE_LO, 32'h0001_0100, 1'h0);
		settle();
		chk("attend pin off", 32'h0, {31'h0, attend});
		wr(`DCL_OFF_LINE_HI, 32'hA5A5_5A5A, 1'h0);
		rd("line hi", `DCL_OFF_LINE_HI, 32'hA5A5_5A5A, 1'h0);
		$display("test line group done");
		// Two-wire and four-wire delays differ, so in the first two cases a swapped wiring bit lands outside the window.
		xmit(32'h0005_020C, 8'h00, 2 * STEP, 2 * STEP + 6);
		xmit(32'h0005_0208, 8'h00, 5 * STEP, 5 * STEP + 6);
		xmit(32'h0005_010C, 8'h1E, 31, 38);
		xmit(32'h0005_0204, 8'h3C, 1, 4);
		xmit(32'h0005_000C, 8'h3C, 61, 68);
		rd("out lo kept", `DCL_OFF_OUTADR_LO, oa[31:0], 1'h0);
		$display("test transmit delays done");
		end_sim();
	end
endmodule
